// File: hdl/rate_converter_routing_config.v
// wishbone register bank for converter routing, target rates and memory page
`include "rate_converter_routing_consts.vh"
`default_nettype none

// Notes on behaviour
// - page bit steers control port memory page
// - page register resets zero, upper bits reserved
// - eight input selectors, reset zero, per pair
// - inputs: serial 0-47, four mics, receiver
// - source codes unused, serial, core, receiver
// - codes 100/101 pick microphone pairs
// - pair field k picks serial 2k,2k+1
// - eight output rate selectors, reset zero
// - converter resamples any input to target
// - output locks to serial, core or internal
// - rate codes 0-12 decode as documented
module rate_converter_routing_config (
	input wire core_clk,
	input wire reset_n,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [17:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	output reg memory_page_select,
	output reg [23:0] converter_source_select,
	output reg [39:0] serial_input_pair_select,
	output reg [31:0] converter_target_rate,
	output reg [15:0] converter_rate_lock_kind,
	output reg [7:0] converter_active
);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// out-of-range selections collapse to unused so the converter stays undriven
	function [2:0] clean_source;
		input [15:0] value;
		reg [2:0] src;
		begin
			src = value[`SOURCE_MSB:`SOURCE_LSB];
			clean_source = `SRC_UNUSED;
			if (src == `SRC_SERIAL)
			begin
				if (value[`PAIR_MSB:`PAIR_LSB] <= `PAIR_LAST)
					clean_source = src;
			end
			else if (src <= `SRC_MIC_HIGH)
				clean_source = src;
		end
	endfunction

	function [3:0] clean_rate;
		input [15:0] value;
		begin
			if (value[`RATE_MSB:`RATE_LSB] <= `RATE_INTERNAL_LAST)
				clean_rate = value[`RATE_MSB:`RATE_LSB];
			else
				clean_rate = `RATE_NONE;
		end
	endfunction

	function [1:0] lock_kind;
		input [3:0] rate;
		begin
			if (rate >= `RATE_SERIAL_OUT_FIRST && rate <= `RATE_SERIAL_OUT_LAST)
				lock_kind = `LOCK_SERIAL_OUT;
			else if (rate == `RATE_CORE)
				lock_kind = `LOCK_CORE;
			else if (rate >= `RATE_INTERNAL_FIRST && rate <= `RATE_INTERNAL_LAST)
				lock_kind = `LOCK_INTERNAL;
			else
				lock_kind = `LOCK_NONE;
		end
	endfunction

	function [15:0] merge_lanes;
		input [15:0] old;
		input [31:0] data;
		input [3:0] sel;
		begin
			merge_lanes = old;
			if (sel[0])
				merge_lanes[7:0] = data[7:0];
			if (sel[1])
				merge_lanes[15:8] = data[15:8];
		end
	endfunction

	// a bank is eight consecutive indices on an eight-aligned base
	function in_bank;
		input [15:0] idx;
		input [15:0] base;
		begin
			in_bank = (idx[15:3] == base[15:3]);
		end
	endfunction

	// the pair field only means something for a serial source
	function [4:0] clean_pair;
		input [15:0] value;
		begin
			if (clean_source(value) == `SRC_SERIAL)
				clean_pair = value[`PAIR_MSB:`PAIR_LSB];
			else
				clean_pair = 5'h00;
		end
	endfunction

	// a converter only runs with both an input and a target rate
	function is_active;
		input [15:0] source_value;
		input [15:0] rate_value;
		begin
			is_active = (clean_source(source_value) != `SRC_UNUSED) &&
				(clean_rate(rate_value) != `RATE_NONE);
		end
	endfunction

	// ------------------------------------------------------------
	// storage and decode
	// ------------------------------------------------------------
	reg [15:0] input_select [0:7];
	reg [15:0] rate_select [0:7];
	reg [15:0] page_select;
	wire [15:0] index = wb_adr_i[17:2];
	wire input_hit = in_bank(index, `CONVERTER_INPUT_SELECT_IDX);
	wire rate_hit = in_bank(index, `CONVERTER_OUTPUT_RATE_SELECT_IDX);
	wire page_hit = (index == `CONTROL_PORT_PAGE_SELECT_IDX);
	wire [2:0] slot = index[2:0];
	wire request = wb_cyc_i & wb_stb_i;
	// taken while ack is low, so a request held past its ack restarts every other cycle
	wire taken = request & ~wb_ack_o;
	// writes land on the edge at which the master sees ack high
	wire write_now = request & wb_ack_o & wb_we_i;
	localparam [1:0] REGION_NONE = 2'h0;
	localparam [1:0] REGION_INPUT = 2'h1;
	localparam [1:0] REGION_RATE = 2'h2;
	localparam [1:0] REGION_PAGE = 2'h3;
	reg [1:0] region;
	reg [31:0] next_read;
	reg [7:0] input_write;
	reg [7:0] rate_write;
	reg page_write;
	integer input_i;
	integer rate_i;
	integer conv;

	// ------------------------------------------------------------
	// address decode and read mux
	// ------------------------------------------------------------
	always @*
	begin
		if (input_hit)
			region = REGION_INPUT;
		else if (rate_hit)
			region = REGION_RATE;
		else if (page_hit)
			region = REGION_PAGE;
		else
			region = REGION_NONE;
	end

	// unmapped indices read as zero
	always @*
	begin
		next_read = 32'h00000000;
		case (region)
			REGION_INPUT:
				next_read[15:0] = input_select[slot];
			REGION_RATE:
				next_read[15:0] = rate_select[slot];
			REGION_PAGE:
				next_read[15:0] = page_select;
			default:
				next_read = 32'h00000000;
		endcase
	end

	// unmapped writes are acknowledged and dropped
	always @*
	begin
		input_write = 8'h00;
		rate_write = 8'h00;
		page_write = 1'b0;
		if (write_now)
		begin
			case (region)
				REGION_INPUT:
					input_write[slot] = 1'b1;
				REGION_RATE:
					rate_write[slot] = 1'b1;
				REGION_PAGE:
					page_write = 1'b1;
				default:
					page_write = 1'b0;
			endcase
		end
	end

	// ------------------------------------------------------------
	// bus slave: ack one cycle after the request is taken
	// ------------------------------------------------------------
	always @(posedge core_clk)
	begin
		if (!reset_n)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= taken;
	end

	// read data stands from the ack until the next access is taken
	always @(posedge core_clk)
	begin
		if (!reset_n)
			wb_dat_o <= 32'h00000000;
		else if (taken)
			wb_dat_o <= next_read;
	end

	// ------------------------------------------------------------
	// register storage; reserved bits are kept and read back
	// ------------------------------------------------------------
	always @(posedge core_clk)
	begin
		if (!reset_n)
			page_select <= `CONTROL_PORT_PAGE_SELECT_RST;
		else if (page_write)
			page_select <= merge_lanes(page_select, wb_dat_i, wb_sel_i);
	end

	always @(posedge core_clk)
	begin
		for (input_i = 0; input_i < `CONVERTER_COUNT; input_i = input_i + 1)
		begin
			if (!reset_n)
				input_select[input_i] <= `CONVERTER_INPUT_SELECT_RST;
			else if (input_write[input_i])
				input_select[input_i] <= merge_lanes(input_select[input_i], wb_dat_i, wb_sel_i);
		end
	end

	always @(posedge core_clk)
	begin
		for (rate_i = 0; rate_i < `CONVERTER_COUNT; rate_i = rate_i + 1)
		begin
			if (!reset_n)
				rate_select[rate_i] <= `CONVERTER_OUTPUT_RATE_SELECT_RST;
			else if (rate_write[rate_i])
				rate_select[rate_i] <= merge_lanes(rate_select[rate_i], wb_dat_i, wb_sel_i);
		end
	end

	// ------------------------------------------------------------
	// routing decode
	// ------------------------------------------------------------
	reg next_memory_page_select;
	reg [23:0] next_converter_source_select;
	reg [39:0] next_serial_input_pair_select;
	reg [31:0] next_converter_target_rate;
	reg [15:0] next_converter_rate_lock_kind;
	reg [7:0] next_converter_active;

	always @*
	begin
		next_memory_page_select = page_select[`PAGE_BIT];
		next_converter_source_select = 24'h000000;
		next_serial_input_pair_select = 40'h0000000000;
		next_converter_target_rate = 32'h00000000;
		next_converter_rate_lock_kind = 16'h0000;
		next_converter_active = 8'h00;
		for (conv = 0; conv < `CONVERTER_COUNT; conv = conv + 1)
		begin
			next_converter_source_select[conv*3 +: 3] = clean_source(input_select[conv]);
			next_serial_input_pair_select[conv*5 +: 5] = clean_pair(input_select[conv]);
			next_converter_target_rate[conv*4 +: 4] = clean_rate(rate_select[conv]);
			next_converter_rate_lock_kind[conv*2 +: 2] =
				lock_kind(clean_rate(rate_select[conv]));
			next_converter_active[conv] = is_active(input_select[conv], rate_select[conv]);
		end
	end

	// ------------------------------------------------------------
	// routing outputs, registered one cycle behind the stored values
	// ------------------------------------------------------------
	// the resampler itself lives elsewhere; it takes any input rate and
	// resamples onto the target chosen here
	always @(posedge core_clk)
	begin
		if (!reset_n)
			memory_page_select <= 1'b0;
		else
			memory_page_select <= next_memory_page_select;
	end

	always @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			converter_source_select <= 24'h000000;
			serial_input_pair_select <= 40'h0000000000;
			converter_target_rate <= 32'h00000000;
			converter_rate_lock_kind <= 16'h0000;
			converter_active <= 8'h00;
		end
		else
		begin
			converter_source_select <= next_converter_source_select;
			serial_input_pair_select <= next_serial_input_pair_select;
			converter_target_rate <= next_converter_target_rate;
			converter_rate_lock_kind <= next_converter_rate_lock_kind;
			converter_active <= next_converter_active;
		end
	end

endmodule // rate_converter_routing_config
`default_nettype wire

// File: inc/rate_converter_routing_consts.vh
// constants for the converter routing configuration register bank
`ifndef RATE_CONVERTER_ROUTING_CONSTS_VH
`define RATE_CONVERTER_ROUTING_CONSTS_VH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define CONVERTER_INPUT_SELECT_IDX 16'hf100
`define CONVERTER_OUTPUT_RATE_SELECT_IDX 16'hf140
`define CONTROL_PORT_PAGE_SELECT_IDX 16'hf899
`define CONVERTER_COUNT 8

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CONVERTER_INPUT_SELECT_RST 16'h0000
`define CONVERTER_OUTPUT_RATE_SELECT_RST 16'h0000
`define CONTROL_PORT_PAGE_SELECT_RST 16'h0000

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PAGE_BIT 0
`define SOURCE_LSB 0
`define SOURCE_MSB 2
`define PAIR_LSB 3
`define PAIR_MSB 7
`define RATE_LSB 0
`define RATE_MSB 3

// ----------------------------------------------------------------
// source codes
// ----------------------------------------------------------------
`define SRC_UNUSED 3'h0
`define SRC_SERIAL 3'h1
`define SRC_CORE 3'h2
`define SRC_SPDIF 3'h3
`define SRC_MIC_LOW 3'h4
`define SRC_MIC_HIGH 3'h5
`define PAIR_LAST 5'h17

// ----------------------------------------------------------------
// target rate codes and lock kinds
// ----------------------------------------------------------------
`define RATE_NONE 4'h0
`define RATE_SERIAL_OUT_FIRST 4'h1
`define RATE_SERIAL_OUT_LAST 4'h4
`define RATE_CORE 4'h5
`define RATE_INTERNAL_FIRST 4'h6
`define RATE_INTERNAL_LAST 4'hc
`define LOCK_NONE 2'h0
`define LOCK_SERIAL_OUT 2'h1
`define LOCK_CORE 2'h2
`define LOCK_INTERNAL 2'h3

`endif

// File: verif/rcr_chk.sv
// checker of bus timing and decoded outputs of the routing register bank
`default_nettype none
module rcr_chk (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [17:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic memory_page_select,
	input wire logic [23:0] converter_source_select,
	input wire logic [39:0] serial_input_pair_select,
	input wire logic [31:0] converter_target_rate,
	input wire logic [15:0] converter_rate_lock_kind,
	input wire logic [7:0] converter_active
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	wire [3:0] r = converter_target_rate[3:0];
	wire pw = wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i[17:2] == 16'hf899;
	logic pd;
	// page bit as last written, so the output is tied to its data
	always_ff @(posedge core_clk)
		if (!reset_n) pd <= 1'b0;
		else if (pw) pd <= wb_dat_i[0];
	sequence page_wr;
		pw ##1 1'b1;
	endsequence
	AST_ACK_PULSE:
		assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	AST_ACK_TAKEN:
		assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
	AST_ACK_CAUSE:
		assert property ($rose(wb_ack_o) |-> $past(wb_stb_i)) else $error("stray ack");
	AST_DAT_HIGH:
		assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0) else $error("upper data");
	AST_PAGE:
		assert property (page_wr |-> ##[0:2] memory_page_select == pd) else $error("page");
	AST_LOCK:
		assert property (converter_rate_lock_kind[1:0] ==
			(r == 0 ? 0 : r < 5 ? 1 : r == 5 ? 2 : 3)) else $error("lock kind");
	AST_ACTIVE:
		assert property (converter_active[0] == (converter_source_select[2:0] != 0 && r != 0))
			else $error("active");
	AST_PAIR:
		assert property (converter_source_select[2:0] != 3'h1 |->
			serial_input_pair_select[4:0] == 5'h0) else $error("pair");
endmodule // rcr_chk
bind rate_converter_routing_config rcr_chk chk (.*);
`default_nettype wire

// File: verif/testbench.sv
// self-checking bench for the routing register bank
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk = 0, reset_n = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
	logic [17:0] wb_adr_i = '0;
	logic [3:0] wb_sel_i = '0;
	logic [31:0] wb_dat_i = '0;
	wire [31:0] wb_dat_o, converter_target_rate;
	wire wb_ack_o, memory_page_select;
	wire [23:0] converter_source_select;
	wire [39:0] serial_input_pair_select;
	wire [15:0] converter_rate_lock_kind;
	wire [7:0] converter_active;
	int miscompares = 0, cmp_count = 0, cycles = 0;
	rate_converter_routing_config dut (.*);
	always #50 core_clk = ~core_clk;
	task automatic give_verdict;
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge core_clk)
		if (++cycles > 5000)
		begin
			miscompares++;
			give_verdict();
		end
	task automatic check(input string what, input logic [39:0] e, g);
		cmp_count++;
		if (e !== g)
		begin
			miscompares++;
			$display("FAIL %s expected %h seen %h", what, e, g);
		end
	endtask
	// one classic cycle; the timeout ends a wait that never sees ack
	task automatic bus(input logic we, input logic [15:0] i, d, input logic [3:0] s);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} <= {2'b11, we, s};
		wb_adr_i <= {i, 2'b00};
		wb_dat_i <= {16'h0, d};
		@(posedge core_clk);
		while (wb_ack_o !== 1'b1) @(posedge core_clk);
		if (!we) check("read", {16'h0, d}, wb_dat_o);
		{wb_cyc_i, wb_stb_i} <= 2'b00;
		repeat (3) @(posedge core_clk);
	endtask
	initial
	begin
		repeat (5) @(posedge core_clk);
		reset_n <= 1;
		@(posedge core_clk);
		for (int n = 0; n < 8; n++)
		begin
			bus(0, 16'hf100 + n, 16'h0, 4'h3);
			bus(0, 16'hf140 + n, 16'h0, 4'h3);
		end
		bus(0, 16'hf899, 16'h0, 4'h3);
		$display("reset test done");
		bus(1, 16'hf899, 16'hfffe, 4'h3);
		check("page", 0, memory_page_select);
		bus(1, 16'hf899, 16'h0001, 4'h3);
		bus(1, 16'hf899, 16'h0000, 4'h2);
		check("page", 1, memory_page_select);
		bus(1, 16'hf898, 16'h0001, 4'h3);
		bus(0, 16'hf898, 16'h0, 4'h3);
		bus(0, 16'hf899, 16'h0001, 4'h3);
		$display("page test done");
		for (int n = 0; n < 8; n++)
		begin
			bus(1, 16'hf100 + n, {8'h0, 5'(3 * n), 3'(n)}, 4'h3);
			check("source", n < 6 ? n : 0, converter_source_select[3*n +: 3]);
			check("pair", n == 1 ? 3 : 0, serial_input_pair_select[5*n +: 5]);
		end
		bus(1, 16'hf101, 16'h00c1, 4'h3);
		check("bad pair", 0, converter_source_select[5:3]);
		bus(1, 16'hf101, 16'h00b9, 4'h3);
		check("last pair", 23, serial_input_pair_select[9:5]);
		$display("source test done");
		for (int r = 0; r < 16; r++)
		begin
			bus(1, 16'hf140 + r % 8, 16'(r), 4'h3);
			check("rate", r < 13 ? r : 0, converter_target_rate[4*(r%8) +: 4]);
			check("lock", (r == 0 || r > 12) ? 0 : r < 5 ? 1 : r == 5 ? 2 : 3,
				converter_rate_lock_kind[2*(r%8) +: 2]);
			check("active", r % 8 > 0 && r % 8 < 6 && r > 0 && r < 13, converter_active[r%8]);
		end
		$display("rate test done");
		give_verdict();
	end
endmodule // testbench
`default_nettype wire
